// ### core/mfp_param_unit.sv
// parameter object store and monitoring for the motor controller
// assumes object accesses are synchronous single-cycle requests
`timescale 1ns/1ps
module mfp_param_unit #(
    parameter int MS_TICK_CYCLES = mfp_pkg::MS_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    // object access port
    input  wire logic        objWrite,
    input  wire logic        objRead,
    input  wire logic [15:0] objIndex,
    input  wire logic [7:0]  objSub,
    input  wire logic [31:0] objWdata,
    output      logic [31:0] objRdata,
    output      logic        objAck,
    output      logic        objErr,
    // torque monitoring
    input  wire logic [15:0] targetTorque,
    input  wire logic [15:0] actualTorque,
    output      logic        torqueReached,
    // encoder feedback
    input  wire logic [31:0] encCount,
    input  wire logic        absPresent,
    input  wire logic [31:0] absPosition,
    input  wire logic        closedLoopReq,
    output      logic        closedLoopOn,
    output      logic [31:0] feedbackPos,
    output      logic [31:0] commutAngle,
    output      logic [31:0] encLinesPerRev,
    output      logic        encSingleEnded,
    // limit switches
    input  wire logic        limitPosOn,
    input  wire logic        limitNegOn,
    input  wire logic        limitErrClear,
    output      logic        limitPosErr,
    output      logic        limitNegErr,
    // clock/direction steps
    input  wire logic        stepMode,
    input  wire logic        stepPulse,
    input  wire logic        stepDir,
    output      logic [31:0] stepScaled
);
    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [15:0]      torqueBand;  // torque_target_band
        logic [15:0]      dwellMs;     // torque_dwell_time_ms
        logic [31:0]      fieldOfs;    // encoder_field_offset
        logic [2:0][31:0] runout;      // runout_compensation_set
        logic [31:0]      edgesRev;    // encoder_edges_per_rev
        logic [31:0]      limitBand;   // limit_overshoot_band
        logic [31:0]      stepMult;    // step_count_multiplier
        logic [31:0]      stepDiv;     // step_count_divider
        logic [31:0]      encCfg;      // encoder_input_config
        logic [31:0]      bootPos;     // power_on_encoder_position
        logic             bootDone;    // boot position taken
        logic             alignValid;  // offset has been loaded
        logic [31:0]      msCnt;       // millisecond prescaler
        logic             msTick;      // one-cycle ms pulse
        logic [15:0]      prevTarget;  // target seen last cycle
        logic             inBand;      // actual within band
        logic             restart;     // target changed
        logic [31:0]      stepAcc;     // accumulated step count
        logic [31:0]      scaled;      // scaled step count
        logic [31:0]      fbPos;       // signed feedback
        logic [31:0]      angle;       // commutation angle
        logic [31:0]      lines;       // lines per revolution
        logic             closedLoop;  // loop closed
        logic [31:0]      rdata;       // read answer
        logic             ack;         // access answered
        logic             err;         // access refused
    } mfp_state_t;

    mfp_state_t st_reg;
    mfp_state_t st_next;

    // combinational helpers
    logic signed [16:0] torqueDev;   // actual minus target
    logic        [16:0] torqueAbs;   // magnitude of deviation
    logic signed [63:0] stepProd;    // count times multiplier
    logic signed [63:0] stepDivEff;  // divider, zero taken as one
    logic signed [63:0] stepQuot;    // scaled quotient
    logic        [31:0] fbNext;      // sign-corrected feedback
    logic        [31:0] absRes;      // magnitude of resolution
    logic        [31:0] rdVal;       // read mux
    logic               rdHit;       // index is mapped
    logic               wrOk;        // index writable
    logic               monitorOn;   // torque watch enabled

    ////////////////////////////////////////////////////////////////////
    // datapath
    always_comb begin
        // deviation from target, symmetric band
        torqueDev = 17'(signed'(actualTorque)) -
                    17'(signed'(targetTorque));
        torqueAbs = torqueDev[16] ? 17'(-torqueDev) : 17'(torqueDev);
        // all-ones band switches the watch off
        monitorOn = (st_reg.torqueBand != mfp_pkg::TORQUE_BAND_OFF);
        // step scaling
        stepProd = 64'(signed'(st_reg.stepAcc)) *
                   64'(signed'(st_reg.stepMult));
        if (st_reg.stepDiv == 32'h00000000) begin
            stepDivEff = 64'sh1; // avoid division by zero
        end else begin
            stepDivEff = 64'(signed'(st_reg.stepDiv));
        end
        stepQuot = stepProd / stepDivEff;
        // feedback sign follows resolution sign
        fbNext = st_reg.edgesRev[31] ? (32'h00000000 - encCount)
                                     : encCount;
        // edges per rev is four times lines
        absRes = st_reg.edgesRev[31] ? (32'h00000000 - st_reg.edgesRev)
                                     : st_reg.edgesRev;
    end

    ////////////////////////////////////////////////////////////////////
    // object read decode
    always_comb begin
        rdVal = 32'h00000000;
        rdHit = 1'b1;
        wrOk  = 1'b1;
        unique case (objIndex)
            mfp_pkg::IDX_TORQUE_BAND: rdVal = {16'h0000, st_reg.torqueBand};
            mfp_pkg::IDX_DWELL_MS:    rdVal = {16'h0000, st_reg.dwellMs};
            mfp_pkg::IDX_FIELD_OFS:   rdVal = st_reg.fieldOfs;
            mfp_pkg::IDX_RUNOUT_SET: begin
                // entry count read-only, entries one to three
                if (objSub == mfp_pkg::SUB_COUNT) begin
                    rdVal = {24'h000000, mfp_pkg::RUNOUT_ENTRIES};
                    wrOk  = 1'b0;
                end else if (objSub <= mfp_pkg::RUNOUT_ENTRIES) begin
                    rdVal = st_reg.runout[objSub[1:0] - 2'h1];
                end else begin
                    rdHit = 1'b0;
                    wrOk  = 1'b0;
                end
            end
            mfp_pkg::IDX_EDGES_REV:   rdVal = st_reg.edgesRev;
            mfp_pkg::IDX_LIMIT_BAND:  rdVal = st_reg.limitBand;
            mfp_pkg::IDX_STEP_MULT:   rdVal = st_reg.stepMult;
            mfp_pkg::IDX_STEP_DIV:    rdVal = st_reg.stepDiv;
            mfp_pkg::IDX_ENC_CFG:     rdVal = st_reg.encCfg;
            mfp_pkg::IDX_BOOT_POS: begin
                rdVal = st_reg.bootPos; // read-only
                wrOk  = 1'b0;
            end
            default: begin
                rdHit = 1'b0;
                wrOk  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;
        // millisecond prescaler
        st_next.msTick = 1'b0;
        if (st_reg.msCnt == 32'(MS_TICK_CYCLES - 1)) begin
            st_next.msCnt  = 32'h00000000;
            st_next.msTick = 1'b1;
        end else begin
            st_next.msCnt = st_reg.msCnt + 32'h00000001;
        end
        // torque band test and target change detect
        // deviation not above band counts as inside
        st_next.inBand     = (torqueAbs <= {1'b0, st_reg.torqueBand});
        st_next.prevTarget = targetTorque;
        st_next.restart    = (targetTorque != st_reg.prevTarget);
        // step accumulation in clock/direction mode
        if (stepMode && stepPulse) begin
            st_next.stepAcc = stepDir ? st_reg.stepAcc - 32'h00000001
                                      : st_reg.stepAcc + 32'h00000001;
        end
        st_next.scaled = stepQuot[31:0];
        // encoder feedback and commutation
        st_next.fbPos = fbNext;
        st_next.angle = fbNext + st_reg.fieldOfs;
        st_next.lines = {2'b00, absRes[31:2]};
        st_next.closedLoop = closedLoopReq && st_reg.alignValid;
        // power-on absolute position, taken once after reset
        if (!st_reg.bootDone) begin
            st_next.bootDone = 1'b1;
            st_next.bootPos  = absPresent ? absPosition
                                          : 32'h00000000;
        end
        // object access answer
        st_next.ack   = objRead || objWrite;
        st_next.err   = (objRead && !rdHit) || (objWrite && !wrOk);
        st_next.rdata = (objRead && rdHit) ? rdVal : 32'h00000000;
        // object writes
        if (objWrite && wrOk) begin
            unique case (objIndex)
                mfp_pkg::IDX_TORQUE_BAND: st_next.torqueBand = objWdata[15:0];
                mfp_pkg::IDX_DWELL_MS:    st_next.dwellMs    = objWdata[15:0];
                mfp_pkg::IDX_FIELD_OFS: begin
                    st_next.fieldOfs   = objWdata;
                    st_next.alignValid = 1'b1;
                end
                mfp_pkg::IDX_RUNOUT_SET:
                    st_next.runout[objSub[1:0] - 2'h1] = objWdata;
                mfp_pkg::IDX_EDGES_REV:   st_next.edgesRev  = objWdata;
                mfp_pkg::IDX_LIMIT_BAND:  st_next.limitBand = objWdata;
                mfp_pkg::IDX_STEP_MULT:   st_next.stepMult  = objWdata;
                mfp_pkg::IDX_STEP_DIV:    st_next.stepDiv   = objWdata;
                mfp_pkg::IDX_ENC_CFG:     st_next.encCfg    = objWdata;
                default: st_next.err = 1'b1;
            endcase
        end
    end

    // state register with documented reset values
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg            <= '0;
            st_reg.torqueBand <= mfp_pkg::RST_TORQUE_BAND;
            st_reg.dwellMs    <= mfp_pkg::RST_DWELL_MS;
            st_reg.fieldOfs   <= mfp_pkg::RST_FIELD_OFS;
            st_reg.runout     <= {3{mfp_pkg::RST_RUNOUT}};
            st_reg.edgesRev   <= mfp_pkg::RST_EDGES_REV;
            st_reg.limitBand  <= mfp_pkg::RST_LIMIT_BAND;
            st_reg.stepMult   <= mfp_pkg::RST_STEP_MULT;
            st_reg.stepDiv    <= mfp_pkg::RST_STEP_DIV;
            st_reg.encCfg     <= mfp_pkg::RST_ENC_CFG;
            st_reg.bootPos    <= mfp_pkg::RST_BOOT_POS;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dwell timer and limit watches
    mfp_dwell_timer u_dwell (
        .clk       (clk),
        .resetn    (resetn),
        .msTick    (st_reg.msTick),
        .monitorOn (monitorOn),
        .inBand    (st_reg.inBand),
        .restart   (st_reg.restart),
        .dwellMs   (st_reg.dwellMs),
        .reached   (torqueReached)
    );

    mfp_limit_watch u_limit_pos (
        .clk          (clk),
        .resetn       (resetn),
        .switchOn     (limitPosOn),
        .position     (st_reg.fbPos),
        .band         (st_reg.limitBand),
        .errClear     (limitErrClear),
        .overshootErr (limitPosErr)
    );

    mfp_limit_watch u_limit_neg (
        .clk          (clk),
        .resetn       (resetn),
        .switchOn     (limitNegOn),
        .position     (st_reg.fbPos),
        .band         (st_reg.limitBand),
        .errClear     (limitErrClear),
        .overshootErr (limitNegErr)
    );

    // outputs straight from state
    assign objRdata       = st_reg.rdata;
    assign objAck         = st_reg.ack;
    assign objErr         = st_reg.err;
    assign closedLoopOn   = st_reg.closedLoop;
    assign feedbackPos    = st_reg.fbPos;
    assign commutAngle    = st_reg.angle;
    assign encLinesPerRev = st_reg.lines;
    assign encSingleEnded = st_reg.encCfg[mfp_pkg::CFG_SINGLE_BIT];
    assign stepScaled     = st_reg.scaled;

    ////////////////////////////////////////////////////////////////////
    // checks
    chk_band_off_quiet: assert property (
        @(posedge clk) disable iff (!resetn)
        (st_reg.torqueBand == mfp_pkg::TORQUE_BAND_OFF) |=> !torqueReached)
        else $error("reached while torque watch off");
    chk_loop_needs_align: assert property (
        @(posedge clk) disable iff (!resetn)
        closedLoopOn |-> $past(st_reg.alignValid) && $past(closedLoopReq))
        else $error("loop closed without alignment");
    chk_runout_count: assert property (
        @(posedge clk) disable iff (!resetn)
        (objRead && objIndex == mfp_pkg::IDX_RUNOUT_SET
            && objSub == mfp_pkg::SUB_COUNT)
        |=> objAck && objRdata == 32'h00000003)
        else $error("runout entry count not three");
    chk_div_zero_as_one: assert property (
        @(posedge clk) disable iff (!resetn)
        (st_reg.stepDiv == 32'h00000000)
        |=> stepScaled == $past(stepProd[31:0]))
        else $error("zero divider not treated as one");
    chk_boot_zero: assert property (
        @(posedge clk) disable iff (!resetn)
        ($rose(st_reg.bootDone) && !$past(absPresent))
        |-> st_reg.bootPos == 32'h00000000 ##1 $stable(st_reg.bootPos))
        else $error("boot position not zero without absolute encoder");
    chk_sign_invert: assert property (
        @(posedge clk) disable iff (!resetn)
        ($past(st_reg.edgesRev[31]) && $stable(st_reg.edgesRev))
        |-> feedbackPos == 32'h00000000 - $past(encCount))
        else $error("feedback sign not inverted");
    chk_boot_readonly: assert property (
        @(posedge clk) disable iff (!resetn)
        (objWrite && objIndex == mfp_pkg::IDX_BOOT_POS)
        |=> objErr && $stable(st_reg.bootPos))
        else $error("boot position accepted a write");
endmodule

// ### include/mfp_pkg.sv
// constants for the motor feedback parameter unit
// assumes a 200 MHz controller clock and object-index host access
package mfp_pkg;
    // object indices
    localparam logic [15:0] IDX_TORQUE_BAND  = 16'h203D;
    localparam logic [15:0] IDX_DWELL_MS     = 16'h203E;
    localparam logic [15:0] IDX_FIELD_OFS    = 16'h2050;
    localparam logic [15:0] IDX_RUNOUT_SET   = 16'h2051;
    localparam logic [15:0] IDX_EDGES_REV    = 16'h2052;
    localparam logic [15:0] IDX_LIMIT_BAND   = 16'h2056;
    localparam logic [15:0] IDX_STEP_MULT    = 16'h2057;
    localparam logic [15:0] IDX_STEP_DIV     = 16'h2058;
    localparam logic [15:0] IDX_ENC_CFG      = 16'h2059;
    localparam logic [15:0] IDX_BOOT_POS     = 16'h205A;
    // subindex of the entry count in the runout set
    localparam logic [7:0]  SUB_COUNT        = 8'h00;
    localparam logic [7:0]  RUNOUT_ENTRIES   = 8'h03;
    // reset values
    localparam logic [15:0] RST_TORQUE_BAND  = 16'h0000;
    localparam logic [15:0] RST_DWELL_MS     = 16'h0000;
    localparam logic [31:0] RST_FIELD_OFS    = 32'h00000000;
    localparam logic [31:0] RST_RUNOUT       = 32'h00000000;
    localparam logic [31:0] RST_EDGES_REV    = 32'h00000000;
    localparam logic [31:0] RST_LIMIT_BAND   = 32'h000001F4;
    localparam logic [31:0] RST_STEP_MULT    = 32'h00000080;
    localparam logic [31:0] RST_STEP_DIV     = 32'h00000001;
    localparam logic [31:0] RST_ENC_CFG      = 32'h00000000;
    localparam logic [31:0] RST_BOOT_POS     = 32'h00000000;
    // torque band value that switches monitoring off
    localparam logic [15:0] TORQUE_BAND_OFF  = 16'hFFFF;
    // field position of the encoder kind bit
    localparam int          CFG_SINGLE_BIT   = 0;
    // millisecond tick derived from clock rate
    localparam int          CLK_PERIOD_PS    = 5000;
    localparam int          MS_IN_PS         = 1000000000;
    localparam int          MS_CYCLES        = MS_IN_PS / CLK_PERIOD_PS;
endpackage

// ### core/mfp_dwell_timer.sv
// dwell timer: counts milliseconds spent inside the torque band
// assumes msTick is a one-cycle pulse once per millisecond
`timescale 1ns/1ps
module mfp_dwell_timer (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        msTick,
    input  wire logic        monitorOn,
    input  wire logic        inBand,
    input  wire logic        restart,
    input  wire logic [15:0] dwellMs,
    output      logic        reached
);
    typedef struct packed {
        logic [15:0] msCount; // whole ms spent in band
        logic        reached; // target-reached flag
    } mfp_dwell_t;

    mfp_dwell_t st_reg;
    mfp_dwell_t st_next;

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;
        if (!monitorOn || !inBand || restart) begin
            // leaving band or new target restarts the wait
            st_next.msCount = 16'h0000;
            st_next.reached = 1'b0; // off means never reached
        end else if (st_reg.msCount >= dwellMs) begin
            st_next.reached = 1'b1; // held in band long enough
        end else if (msTick) begin
            st_next.msCount = st_reg.msCount + 16'h0001;
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reached = st_reg.reached;

    ////////////////////////////////////////////////////////////////////
    // checks
    chk_leave_clears: assert property (
        @(posedge clk) disable iff (!resetn)
        (!inBand || restart) |=> !reached)
        else $error("reached survived band exit or restart");
    chk_reach_needs_dwell: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(reached) |-> $past(inBand) && $past(monitorOn)
            && ($past(st_reg.msCount) >= $past(dwellMs)))
        else $error("reached without full dwell in band");
endmodule

// ### core/mfp_limit_watch.sv
// overshoot watch for one limit switch
// assumes position and switch level are synchronous to clk
`timescale 1ns/1ps
module mfp_limit_watch (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        switchOn,
    input  wire logic [31:0] position,
    input  wire logic [31:0] band,
    input  wire logic        errClear,
    output      logic        overshootErr
);
    typedef struct packed {
        logic        swPrev;  // switch level last cycle
        logic [31:0] edgePos; // position where switch closed
        logic        err;     // sticky overshoot error
    } mfp_limit_t;

    mfp_limit_t  st_reg;
    mfp_limit_t  st_next;
    logic [31:0] travel; // distance past the switch edge
    logic        beyond; // travel exceeds band

    ////////////////////////////////////////////////////////////////////
    // travel since switch actuation, either direction
    always_comb begin
        travel = position - st_reg.edgePos;
        if (travel[31]) begin
            travel = 32'h00000000 - travel;
        end
        beyond = switchOn && st_reg.swPrev && (travel > band);
    end

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.swPrev = switchOn;
        if (switchOn && !st_reg.swPrev) begin
            st_next.edgePos = position; // mark actuation point
        end
        if (beyond) begin
            st_next.err = 1'b1; // set wins over clear
        end else if (errClear) begin
            st_next.err = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign overshootErr = st_reg.err;

    ////////////////////////////////////////////////////////////////////
    // checks
    chk_err_cause: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(overshootErr) |-> $past(beyond))
        else $error("overshoot error without travel beyond band");
    chk_err_raised: assert property (
        @(posedge clk) disable iff (!resetn)
        beyond |=> overshootErr)
        else $error("travel beyond band not flagged");
endmodule

// ### tb/mfp_feedback_model.sv
// partner model: encoder, positive limit switch, step source
// assumes the bench drives run and steps at the falling edge
`timescale 1ns/1ps
module mfp_feedback_model #(
    parameter int SW_POS = 100 // switch actuation point
) (
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic        steps,
    output      logic [31:0] encCount,
    output      logic        limitPosOn,
    output      logic        stepPulse
);
    initial encCount = 32'h0;
    initial stepPulse = 1'b0;
    // encoder moves one count a cycle; pulses keep one idle gap
    always @(posedge clk) begin
        if (run) encCount <= encCount + 32'h1;
        stepPulse <= steps & ~stepPulse;
    end
    // switch stays actuated past its point
    assign limitPosOn = $signed(encCount) >= SW_POS;
endmodule

// ### tb/motor_feedback_param_unit_test.sv
// self-checking bench for the motor feedback parameter unit
// assumes each object access is answered one cycle later
`timescale 1ns/1ps
module motor_feedback_param_unit_test;
    logic        clk = 0, resetn = 0, objWrite = 0, objRead = 0;
    logic [15:0] objIndex = 0, targetTorque = 0, actualTorque = 0;
    logic [7:0]  objSub = 0;
    logic [31:0] objWdata = 0, absPosition = 0, r, objRdata, encCount;
    logic [31:0] feedbackPos, commutAngle, encLinesPerRev, stepScaled;
    logic        absPresent = 0, closedLoopReq = 0, run = 0, steps = 0;
    logic        objAck, objErr, torqueReached, closedLoopOn, limitPosOn;
    logic        encSingleEnded, limitPosErr, limitNegErr, stepPulse;
    logic        limitErrClear = 0;
    int          failures = 0, samples_checked = 0, seed = 32'h1D1A, i, m;
    logic [15:0] idx [6] = '{16'h203D, 16'h203E, 16'h2051, 16'h2051,
                             16'h2051, 16'h2050};
    logic [7:0]  sb [6] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h00};
    mfp_param_unit #(.MS_TICK_CYCLES(10)) mfp_param_unit_i (.clk, .resetn,
        .objWrite, .objRead, .objIndex, .objSub, .objWdata, .objRdata,
        .objAck, .objErr, .targetTorque, .actualTorque, .torqueReached,
        .encCount, .absPresent, .absPosition, .closedLoopReq, .closedLoopOn,
        .feedbackPos, .commutAngle, .encLinesPerRev, .encSingleEnded,
        .limitPosOn, .limitNegOn(1'b0), .limitErrClear, .limitPosErr,
        .limitNegErr, .stepMode(1'b1), .stepPulse, .stepDir(1'b0),
        .stepScaled);
    mfp_feedback_model mfp_feedback_model_i (.clk, .run, .steps, .encCount,
        .limitPosOn, .stepPulse);
    always #2.5 clk = ~clk;
    // value compare
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    // one object access, answer checked one cycle on
    task automatic obj(logic wr, logic [15:0] ix, logic [7:0] sub,
                       logic [31:0] wd, logic err, logic [31:0] exp);
        @(negedge clk);
        {objWrite, objRead, objIndex, objSub, objWdata} = {wr, ~wr, ix, sub, wd};
        @(negedge clk);
        {objWrite, objRead} = 2'b00;
        cmp("ack", 1, objAck);
        cmp("err", err, objErr);
        if (!wr && !err) cmp("rdata", exp, objRdata);
    endtask
    task automatic rst(logic abs);
        absPresent = abs;
        absPosition = $random(seed);
        resetn = 0;
        repeat (8) @(negedge clk);
        resetn = 1;
        repeat (2) @(negedge clk);
    endtask
    // bounded wait for target reached; a timeout ends the run
    task automatic wait_hi(int n);
        for (i = 0; i < n && torqueReached !== 1'b1; i++) @(negedge clk);
        cmp("reached", 1, torqueReached);
        if (torqueReached !== 1'b1) wrap_up;
    endtask
    function automatic logic [31:0] scaled(int n, int mul, int d);
        return n * mul / (d == 0 ? 1 : d);
    endfunction
    task automatic wrap_up;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        rst(0);
        obj(0, 16'h205A, 0, 0, 0, 0);
        obj(0, 16'h2056, 0, 0, 0, 32'h1F4);
        obj(0, 16'h2057, 0, 0, 0, 32'h80);
        obj(0, 16'h2058, 0, 0, 0, 32'h1);
        obj(0, 16'h2051, 0, 0, 0, 32'h3);
        obj(1, 16'h2051, 0, 0, 1, 0);
        obj(0, 16'h2053, 0, 0, 1, 0);
        rst(1);
        obj(1, 16'h205A, 0, 0, 1, 0);
        obj(0, 16'h205A, 0, 0, 0, absPosition);
        closedLoopReq = 1;
        @(negedge clk);
        cmp("loop", 0, closedLoopOn);
        foreach (idx[k]) begin
            r = $random(seed);
            obj(1, idx[k], sb[k], r, 0, 0);
            obj(0, idx[k], sb[k], 0, 0, k < 2 ? r & 32'hFFFF : r);
        end
        run = 1;
        repeat (20) @(negedge clk);
        run = 0;
        obj(1, 16'h2052, 0, 32'hFFFFF060, 0, 0);
        repeat (3) @(negedge clk);
        cmp("loop", 1, closedLoopOn);
        cmp("fb", 32'hFFFFFFEC, feedbackPos);
        cmp("lines", 32'h3E8, encLinesPerRev);
        cmp("angle", r - 32'h14, commutAngle);
        for (i = 1; i >= 0; i--) begin
            obj(1, 16'h2059, 0, i, 0, 0);
            repeat (2) @(negedge clk);
            cmp("kind", i, encSingleEnded);
        end
        m = ($random(seed) % 8) - 9;
        obj(1, 16'h2057, 0, m, 0, 0);
        for (int p = 0; p < 2; p++) begin
            obj(1, 16'h2058, 0, 2 - 2 * p, 0, 0);
            steps = 1;
            repeat (10) @(negedge clk);
            steps = 0;
            repeat (3) @(negedge clk);
            cmp("steps", scaled(5 * (p + 1), m, 2 - 2 * p), stepScaled);
        end
        obj(1, 16'h203D, 0, 32'hA, 0, 0);
        obj(1, 16'h203E, 0, 32'h2, 0, 0);
        targetTorque = 100;
        actualTorque = 90;
        repeat (8) @(negedge clk);
        cmp("early", 0, torqueReached);
        wait_hi(40);
        actualTorque = 111;
        repeat (3) @(negedge clk);
        cmp("left", 0, torqueReached);
        actualTorque = 110;
        wait_hi(40);
        targetTorque = 101;
        repeat (2) @(negedge clk);
        cmp("retarget", 0, torqueReached);
        obj(1, 16'h203D, 0, 32'hFFFF, 0, 0);
        repeat (40) @(negedge clk);
        cmp("off", 0, torqueReached);
        run = 1;
        repeat (560) @(negedge clk);
        cmp("inside", 0, limitPosErr);
        repeat (40) @(negedge clk);
        run = 0;
        repeat (2) @(negedge clk);
        cmp("over", 1, limitPosErr);
        cmp("neg", 0, limitNegErr);
        limitErrClear = 1;
        @(negedge clk);
        limitErrClear = 0;
        @(negedge clk);
        cmp("sticky", 1, limitPosErr);
        wrap_up;
    end
endmodule
